// file: idrc_map.svh
// offsets, field positions, reset values and timing counts of the dma and refresh block
`ifndef IDRC_MAP_SVH
`define IDRC_MAP_SVH

`define IDRC_REQ_OFS 12'h000
`define IDRC_MASK_OFS 12'h004
`define IDRC_FAST_OFS 12'h008
`define IDRC_STAT_OFS 12'h00C
`define IDRC_HIPAGE_OFS 12'h010
`define IDRC_CH_BASE 5'h02
`define IDRC_CH_ADDR 2'h0
`define IDRC_CH_CNT 2'h1
`define IDRC_CH_PAGE 2'h2
`define IDRC_CH_MODE 2'h3

`define IDRC_MODE_XFER 1:0
`define IDRC_MODE_AUTO 2
`define IDRC_MODE_DEC 3
`define IDRC_MODE_SEL 5:4
`define IDRC_MODE_RST 6'h00
`define IDRC_MODE_CASC_RST 6'h30
`define IDRC_MASK_RST 8'hFF
`define IDRC_CASC_CH 3'h4
`define IDRC_CASC_BIT 8'h10
`define IDRC_REF_QMAX 3'h4
`define IDRC_FAST_BUF_BYTES 3'h4

`define IDRC_CLK_NS 100
`define IDRC_COMPAT_STROBE_NS 400

`define IDRC_RESP_OKAY 2'h0
`define IDRC_RESP_SLVERR 2'h2

`endif

// file: idrc_pkg.sv
// types of the dma and refresh block
`default_nettype none
package idrc_pkg;
	typedef enum logic [3:0] {
		ST_IDLE, ST_HOLD, ST_ADDR, ST_STROBE, ST_END, ST_CASCADE,
		ST_REF_ADDR, ST_REF_STROBE, ST_REF_END
	} idrc_state_t;
	typedef enum logic [1:0] {XFER_VERIFY, XFER_WRITE, XFER_READ, XFER_ILLEGAL} idrc_xfer_t;
	typedef enum logic [1:0] {MODE_DEMAND, MODE_SINGLE, MODE_BLOCK, MODE_CASCADE} idrc_mode_t;
endpackage
`default_nettype wire

// file: idrc_top.sv
// seven-channel isa dma engine with refresh generation and axi4-lite registers
`timescale 1ns/1ps
`include "idrc_map.svh"
`default_nettype none

module idrc_top #(
	parameter int COMPAT_STROBE_NS = `IDRC_COMPAT_STROBE_NS
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic [11:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [11:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic [7:0] dreq_i,
	output logic [7:0] dack_n_o,
	output logic dack_oe_n_o,
	output logic aen_o,
	output logic aen_oe_n_o,
	output logic bale_o,
	input wire logic tc_i,
	output logic tc_o,
	output logic tc_oe_n_o,
	output logic [23:0] isa_addr_o,
	output logic isa_addr_oe_n_o,
	output logic memr_n_o,
	output logic memw_n_o,
	output logic smemr_n_o,
	output logic smemw_n_o,
	output logic ior_n_o,
	output logic iow_n_o,
	input wire logic refresh_n_i,
	output logic refresh_n_o,
	output logic refresh_oe_n_o,
	input wire logic chrdy_i,
	input wire logic refresh_tick_i,
	input wire logic pci_abort_i,
	input wire logic pci_hold_acknowledge_n_i,
	output logic pci_hold_request_n_o,
	output logic isa_stall_o,
	output logic buf_flush_o,
	output logic io0_forward_o
);
	import idrc_pkg::*;

	localparam int STROBE_CYC_I = (COMPAT_STROBE_NS + `IDRC_CLK_NS - 1) / `IDRC_CLK_NS;
	localparam logic [3:0] STROBE_CYC = (STROBE_CYC_I < 1) ? 4'h1 : 4'(STROBE_CYC_I);

	logic [15:0] base_addr [8];
	logic [15:0] cur_addr [8];
	logic [15:0] base_cnt [8];
	logic [15:0] cur_cnt [8];
	logic [7:0] page [8];
	logic [5:0] mode [8];
	logic [7:0] sw_req, mask, tc_flag, fast_sel, hi_page;
	logic abort_flag;
	idrc_state_t state;
	logic [2:0] ch;
	logic [3:0] strobe_cnt;
	logic [2:0] ref_q;
	logic [7:0] ref_addr;
	logic ref_master, ext_mode, strap_done;
	logic [1:0] strap_wait;
	logic [2:0] buf_cnt;
	logic [7:0] dreq_s1, dreq_s2;
	logic hlda_s1, hlda_s2, refr_s1, refr_s2, rdy_s1, rdy_s2, tc_s1, tc_s2;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [31:0] rd_data;
	logic rd_ok, wr_ok, do_write;

	// lowest pending channel wins, as the classic fixed priority
	function automatic logic [3:0] pick(input logic [7:0] p);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 7; i >= 0; i--) begin
			if (p[i]) begin
				r = {1'b1, 3'(i)};
			end
		end
		return r;
	endfunction

	function automatic logic is_fast(input logic [7:0] sel, input logic [2:0] c);
		return (sel[3] && sel[2:0] == c) || (sel[7] && sel[6:4] == c);
	endfunction

	function automatic logic [23:0] dma_addr(input logic [2:0] c, input logic [7:0] pg,
			input logic [15:0] a);
		return c[2] ? {pg[7:1], a, 1'b0} : {pg, a};
	endfunction

	// two-flop synchronisers for the dreq, hold acknowledge, refresh, chrdy and tc inputs
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			dreq_s1 <= 8'h00;
			dreq_s2 <= 8'h00;
			{hlda_s1, hlda_s2, refr_s1, refr_s2} <= 4'hF;
			{rdy_s1, rdy_s2, tc_s1, tc_s2} <= 4'hC;
		end else if (ce_i) begin
			dreq_s1 <= dreq_i;
			dreq_s2 <= dreq_s1;
			hlda_s1 <= pci_hold_acknowledge_n_i;
			hlda_s2 <= hlda_s1;
			refr_s1 <= refresh_n_i;
			refr_s2 <= refr_s1;
			rdy_s1 <= chrdy_i;
			rdy_s2 <= rdy_s1;
			tc_s1 <= tc_i;
			tc_s2 <= tc_s1;
		end
	end

	logic [7:0] pend;
	logic [3:0] picked;
	logic fast, last, adv;
	idrc_mode_t cmode;
	idrc_xfer_t cxfer;
	logic [23:0] cur_dma;
	assign pend = (dreq_s2 | sw_req) & ~mask & ~`IDRC_CASC_BIT;
	assign picked = pick(pend);
	assign fast = is_fast(fast_sel, ch);
	assign cmode = idrc_mode_t'(mode[ch][`IDRC_MODE_SEL]);
	assign cxfer = idrc_xfer_t'(mode[ch][`IDRC_MODE_XFER]);
	assign last = cur_cnt[ch] == 16'h0000;
	assign adv = ce_i && state == ST_END;
	assign cur_dma = dma_addr(ch, page[ch], cur_addr[ch]);

	// strap waits until the synchroniser has filled; its reset value is no strap
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ext_mode <= 1'b0;
			strap_done <= 1'b0;
			strap_wait <= 2'h0;
		end else if (ce_i && !strap_done) begin
			if (strap_wait == 2'h2) begin
				ext_mode <= tc_s2;
				strap_done <= 1'b1;
			end else begin
				strap_wait <= strap_wait + 2'h1;
			end
		end
	end

	// transfer and refresh sequencer
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			state <= ST_IDLE;
			ch <= 3'h0;
			strobe_cnt <= 4'h0;
			ref_master <= 1'b0;
		end else if (ce_i) begin
			unique case (state)
				ST_IDLE: begin
					if (ref_q != 3'h0) begin
						state <= ST_REF_ADDR;
						ref_master <= 1'b0;
					end else if (picked[3] && hlda_s2) begin
						// a stale grant from the last hold must drain first
						state <= ST_HOLD;
						ch <= picked[2:0];
					end
				end
				ST_HOLD: begin
					if (!hlda_s2) begin
						state <= (cmode == MODE_CASCADE) ? ST_CASCADE : ST_ADDR;
					end else if (!pend[ch] && cmode != MODE_CASCADE) begin
						state <= ST_IDLE;
					end
				end
				ST_ADDR: begin
					strobe_cnt <= fast ? 4'h1 : STROBE_CYC;
					state <= ST_STROBE;
				end
				ST_STROBE: begin
					if (strobe_cnt > 4'h1) begin
						strobe_cnt <= strobe_cnt - 4'h1;
					end else if (fast || rdy_s2) begin
						state <= ST_END;
					end
				end
				ST_END: begin
					if (last || cmode == MODE_SINGLE) begin
						state <= ST_IDLE;
					end else if (cmode == MODE_BLOCK) begin
						state <= ST_ADDR;
					end else begin
						state <= (pend[ch] && ref_q == 3'h0) ? ST_ADDR : ST_IDLE;
					end
				end
				ST_CASCADE: begin
					if (!refr_s2) begin
						state <= ST_REF_ADDR;
						ref_master <= 1'b1;
					end else if (!dreq_s2[ch]) begin
						state <= ST_IDLE;
					end
				end
				ST_REF_ADDR: begin
					strobe_cnt <= STROBE_CYC;
					state <= ST_REF_STROBE;
				end
				ST_REF_STROBE: begin
					if (strobe_cnt > 4'h1) begin
						strobe_cnt <= strobe_cnt - 4'h1;
					end else if (rdy_s2) begin
						state <= ST_REF_END;
					end
				end
				ST_REF_END: begin
					if (!ref_master) begin
						state <= ST_IDLE;
					end else if (refr_s2) begin
						state <= ST_CASCADE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// refresh queue: a tick in the same cycle as a completion is kept unless the queue already holds four
	logic ref_inc, ref_dec;
	assign ref_inc = refresh_tick_i && ref_q < `IDRC_REF_QMAX;
	assign ref_dec = state == ST_REF_END && !ref_master;
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ref_q <= 3'h0;
			ref_addr <= 8'h00;
		end else if (ce_i) begin
			ref_q <= ref_q + {2'h0, ref_inc} - {2'h0, ref_dec};
			if (state == ST_REF_END && (!ref_master || refr_s2)) begin
				ref_addr <= ref_addr + 8'h01;
			end
		end
	end

	// fast transfers collect in the four-byte buffer before the pci side moves them
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			buf_cnt <= 3'h0;
			buf_flush_o <= 1'b0;
		end else if (ce_i) begin
			buf_flush_o <= 1'b0;
			if (adv && fast) begin
				if (buf_cnt + (ch[2] ? 3'h2 : 3'h1) >= `IDRC_FAST_BUF_BYTES || last) begin
					buf_cnt <= 3'h0;
					buf_flush_o <= 1'b1;
				end else begin
					buf_cnt <= buf_cnt + (ch[2] ? 3'h2 : 3'h1);
				end
			end
		end
	end

	// pin drive, registered from the sequencer state
	logic xfer_on, ref_on, strb, below16, below1, own_ref;
	assign xfer_on = state == ST_ADDR || state == ST_STROBE || state == ST_END;
	assign ref_on = state == ST_REF_ADDR || state == ST_REF_STROBE || state == ST_REF_END;
	assign own_ref = ref_on && !ref_master;
	assign strb = state == ST_STROBE || state == ST_REF_STROBE;
	assign below16 = hi_page == 8'h00;
	assign below1 = below16 && cur_dma[23:20] == 4'h0;
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			dack_n_o <= 8'hFF;
			{aen_o, bale_o, tc_o} <= 3'h0;
			{dack_oe_n_o, aen_oe_n_o, tc_oe_n_o, isa_addr_oe_n_o} <= 4'hF;
			isa_addr_o <= 24'h00_0000;
			{memr_n_o, memw_n_o, smemr_n_o, smemw_n_o, ior_n_o, iow_n_o} <= 6'h3F;
			{refresh_n_o, refresh_oe_n_o, pci_hold_request_n_o} <= 3'h7;
			{isa_stall_o, io0_forward_o} <= 2'h0;
		end else if (ce_i) begin
			dack_n_o <= (xfer_on || state == ST_CASCADE || (ref_on && ref_master)) ?
				~(8'h01 << ch) : 8'hFF;
			aen_o <= xfer_on || own_ref;
			bale_o <= xfer_on || ref_on;
			tc_o <= state == ST_END && last;
			dack_oe_n_o <= ext_mode || !strap_done;
			aen_oe_n_o <= ext_mode || !strap_done;
			tc_oe_n_o <= ext_mode || !strap_done;
			isa_addr_o <= ref_on ? {16'h0000, ref_addr} : cur_dma;
			isa_addr_oe_n_o <= !(xfer_on || ref_on);
			memr_n_o <= !(strb && (ref_on || (xfer_on && cxfer == XFER_READ && below16)));
			smemr_n_o <= !(strb && (own_ref || (xfer_on && cxfer == XFER_READ && below1)));
			memw_n_o <= !(strb && xfer_on && cxfer == XFER_WRITE && below16);
			smemw_n_o <= !(strb && xfer_on && cxfer == XFER_WRITE && below1);
			ior_n_o <= !(strb && xfer_on && cxfer == XFER_WRITE);
			iow_n_o <= !(strb && xfer_on && cxfer == XFER_READ);
			refresh_n_o <= !own_ref;
			refresh_oe_n_o <= !own_ref;
			pci_hold_request_n_o <= !(state == ST_HOLD || xfer_on || state == ST_CASCADE
				|| (ref_on && ref_master));
			isa_stall_o <= ref_on;
			io0_forward_o <= ext_mode;
		end
	end

	// axi4-lite write: address and data taken in either order, then the response
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o <= 1'b1;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= `IDRC_RESP_OKAY;
			aw_addr <= 12'h000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (ce_i) begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_addr <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
				s_axi_wready_o <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= wr_ok ? `IDRC_RESP_OKAY : `IDRC_RESP_SLVERR;
			end
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o <= 1'b1;
			end
		end
	end
	assign do_write = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;

	logic ch_hit;
	logic [2:0] wch;
	logic [1:0] wfld;
	assign ch_hit = aw_addr[11:7] == `IDRC_CH_BASE;
	assign wch = aw_addr[6:4];
	assign wfld = aw_addr[3:2];
	assign wr_ok = ch_hit || aw_addr == `IDRC_REQ_OFS || aw_addr == `IDRC_MASK_OFS
		|| aw_addr == `IDRC_FAST_OFS || aw_addr == `IDRC_STAT_OFS
		|| aw_addr == `IDRC_HIPAGE_OFS;

	// software writes and engine updates share one process; the engine's set wins
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < 8; i++) begin
				base_addr[i] <= 16'h0000;
				cur_addr[i] <= 16'h0000;
				base_cnt[i] <= 16'h0000;
				cur_cnt[i] <= 16'h0000;
				page[i] <= 8'h00;
				mode[i] <= (i == 4) ? `IDRC_MODE_CASC_RST : `IDRC_MODE_RST;
			end
			sw_req <= 8'h00;
			mask <= `IDRC_MASK_RST;
			tc_flag <= 8'h00;
			fast_sel <= 8'h00;
			hi_page <= 8'h00;
			abort_flag <= 1'b0;
		end else if (ce_i) begin
			if (do_write && w_strb[0]) begin
				if (ch_hit && wfld == `IDRC_CH_ADDR) begin
					base_addr[wch] <= w_data[15:0];
					cur_addr[wch] <= w_data[15:0];
				end
				if (ch_hit && wfld == `IDRC_CH_CNT) begin
					base_cnt[wch] <= w_data[15:0];
					cur_cnt[wch] <= w_data[15:0];
				end
				if (ch_hit && wfld == `IDRC_CH_PAGE) begin
					page[wch] <= w_data[7:0];
				end
				if (ch_hit && wfld == `IDRC_CH_MODE) begin
					mode[wch] <= w_data[5:0];
				end
				if (aw_addr == `IDRC_REQ_OFS) begin
					sw_req <= sw_req | w_data[7:0];
				end
				if (aw_addr == `IDRC_MASK_OFS) begin
					mask <= w_data[7:0];
				end
				if (aw_addr == `IDRC_FAST_OFS) begin
					fast_sel <= w_data[7:0];
				end
				if (aw_addr == `IDRC_STAT_OFS) begin
					tc_flag <= tc_flag & ~w_data[7:0];
					abort_flag <= abort_flag && !w_data[20];
				end
				if (aw_addr == `IDRC_HIPAGE_OFS) begin
					hi_page <= w_data[7:0];
				end
			end
			// isa data is not refetched after an abort; the flag only reports it
			if (pci_abort_i && xfer_on) begin
				abort_flag <= 1'b1;
			end
			if (adv) begin
				if (mode[ch][`IDRC_MODE_DEC]) begin
					cur_addr[ch] <= cur_addr[ch] - 16'h0001;
				end else begin
					cur_addr[ch] <= cur_addr[ch] + 16'h0001;
				end
				cur_cnt[ch] <= cur_cnt[ch] - 16'h0001;
				if (last) begin
					tc_flag[ch] <= 1'b1;
					sw_req[ch] <= 1'b0;
					if (mode[ch][`IDRC_MODE_AUTO]) begin
						cur_addr[ch] <= base_addr[ch];
						cur_cnt[ch] <= base_cnt[ch];
					end else begin
						mask[ch] <= 1'b1;
					end
				end
			end
		end
	end

	// axi4-lite read: one answer per request, unmapped words answer slverr
	always_comb begin
		rd_ok = 1'b1;
		rd_data = 32'h0000_0000;
		if (s_axi_araddr_i[11:7] == `IDRC_CH_BASE) begin
			unique case (s_axi_araddr_i[3:2])
				`IDRC_CH_ADDR: rd_data = {16'h0000, cur_addr[s_axi_araddr_i[6:4]]};
				`IDRC_CH_CNT: rd_data = {16'h0000, cur_cnt[s_axi_araddr_i[6:4]]};
				`IDRC_CH_PAGE: rd_data = {24'h00_0000, page[s_axi_araddr_i[6:4]]};
				`IDRC_CH_MODE: rd_data = {26'h000_0000, mode[s_axi_araddr_i[6:4]]};
			endcase
		end else if (s_axi_araddr_i == `IDRC_REQ_OFS) begin
			rd_data = {24'h00_0000, sw_req};
		end else if (s_axi_araddr_i == `IDRC_MASK_OFS) begin
			rd_data = {24'h00_0000, mask};
		end else if (s_axi_araddr_i == `IDRC_FAST_OFS) begin
			rd_data = {24'h00_0000, fast_sel};
		end else if (s_axi_araddr_i == `IDRC_STAT_OFS) begin
			rd_data = {8'h00, 2'h0, ext_mode, abort_flag, state != ST_IDLE, ref_q, dreq_s2,
				tc_flag};
		end else if (s_axi_araddr_i == `IDRC_HIPAGE_OFS) begin
			rd_data = {24'h00_0000, hi_page};
		end else begin
			rd_ok = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0000_0000;
			s_axi_rresp_o <= `IDRC_RESP_OKAY;
		end else if (ce_i) begin
			if (s_axi_arvalid_i && s_axi_arready_o) begin
				s_axi_arready_o <= 1'b0;
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o <= rd_data;
				s_axi_rresp_o <= rd_ok ? `IDRC_RESP_OKAY : `IDRC_RESP_SLVERR;
			end else if (s_axi_rvalid_o && s_axi_rready_i) begin
				s_axi_rvalid_o <= 1'b0;
				s_axi_arready_o <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// file: idrc_pad.sv
// unused
`timescale 1ns/1ps

// file: idrc_monitor.sv
// checker of dma, refresh and strap relations at the top pins
`timescale 1ns/1ps
`default_nettype none
module idrc_monitor (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [7:0] dack_n_o,
	input wire logic dack_oe_n_o,
	input wire logic aen_o,
	input wire logic aen_oe_n_o,
	input wire logic bale_o,
	input wire logic tc_o,
	input wire logic tc_oe_n_o,
	input wire logic [23:0] isa_addr_o,
	input wire logic memr_n_o,
	input wire logic smemr_n_o,
	input wire logic smemw_n_o,
	input wire logic refresh_n_o,
	input wire logic pci_hold_request_n_o,
	input wire logic isa_stall_o,
	input wire logic io0_forward_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	// grants on channels 4 to 7 left out, as a cascade grant there gives the master aen
	a_dma_aen_bale: assert property (!dack_oe_n_o && !(&dack_n_o[3:0]) |-> aen_o && bale_o)
		else $error("aen or bale low during dma");
	a_dack_after_hold: assert property ($fell(&dack_n_o) |-> !pci_hold_request_n_o)
		else $error("dack without hold request");
	a_smem_below_1m: assert property (!smemr_n_o || !smemw_n_o |-> isa_addr_o[23:20] == 4'h0)
		else $error("system strobe above 1 mbyte");
	a_int_refresh_pins: assert property (!refresh_n_o && !memr_n_o |->
		!smemr_n_o && aen_o && bale_o && isa_stall_o)
		else $error("internal refresh pins wrong");
	a_refresh_first: assert property ($fell(memr_n_o) && !refresh_n_o |-> $past(refresh_n_o) == 1'b0)
		else $error("refresh indication late");
	a_master_refresh: assert property (!memr_n_o && smemr_n_o && !dack_n_o[5] |-> bale_o && !aen_o)
		else $error("master refresh aen or bale wrong");
	a_tc_one_cycle: assert property (tc_o |=> !tc_o)
		else $error("terminal count longer than one cycle");
	a_ext_tristate: assert property (io0_forward_o |-> aen_oe_n_o && tc_oe_n_o && dack_oe_n_o)
		else $error("external mode pins driven");
	a_cascade_link: assert property (dack_n_o[4])
		else $error("cascade channel acknowledged");
endmodule
bind idrc_top idrc_monitor u_idrc_monitor (.clk_sys_i, .rst_n_i, .dack_n_o, .dack_oe_n_o, .aen_o,
	.aen_oe_n_o, .bale_o, .tc_o, .tc_oe_n_o, .isa_addr_o, .memr_n_o, .smemr_n_o, .smemw_n_o,
	.refresh_n_o, .pci_hold_request_n_o, .isa_stall_o, .io0_forward_o);
`default_nettype wire

// file: idrc_isa_model.sv
// isa dma slaves and one cascaded isa master on the far side of the pins
`timescale 1ns/1ps
`default_nettype none
module idrc_isa_model (
	input wire logic clk_sys_i,
	input wire logic [7:0] req_set_i,
	input wire logic casc_i,
	input wire logic slow_i,
	input wire logic [7:0] dack_n_i,
	input wire logic tc_i,
	input wire logic memr_n_i,
	output logic [7:0] dreq_o,
	output logic chrdy_o,
	output logic refresh_n_o
);
	logic [7:0] last_ack = 8'h00;
	logic [4:0] mcnt = 5'h00;
	logic [2:0] wcnt = 3'h0;
	initial dreq_o = 8'h00;
	// a slave request stays up until its own terminal count, the master's until mcnt reaches 14
	always @(posedge clk_sys_i) begin
		if (dack_n_i != 8'hFF)
			last_ack <= ~dack_n_i;
		mcnt <= (casc_i && !dack_n_i[5]) ? mcnt + 5'h01 : 5'h00;
		dreq_o <= (dreq_o | req_set_i) & ~(tc_i ? last_ack : 8'h00)
			& ~((mcnt == 5'h0E) ? 8'h20 : 8'h00);
		wcnt <= (slow_i && !memr_n_i && wcnt < 3'h7) ? wcnt + 3'h1 : 3'h0;
	end
	// pulled-up line: high whenever nobody holds it low
	assign chrdy_o = !(slow_i && !memr_n_i && wcnt < 3'h4);
	// master floats its lines and asks for a refresh while it owns the bus
	assign refresh_n_o = !(mcnt >= 5'h04 && mcnt < 5'h0C);
	// no data bus modelled, so no slave ever drives it in a refresh
endmodule
`default_nettype wire

// file: tb_idrc_top.sv
// self-checking bench of the dma and refresh block
`timescale 1ns/1ps
`include "idrc_map.svh"
`default_nettype none
module tb_idrc_top;
	logic clk_sys_i = 1'b0, rst_n_i = 1'b0, tc_i = 1'b0, refresh_tick_i = 1'b0;
	logic [11:0] s_axi_awaddr_i = 12'h000, s_axi_araddr_i = 12'h000;
	logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
	logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, pci_hold_acknowledge_n_i = 1'b1;
	logic [31:0] s_axi_wdata_i = 32'h0000_0000, rdata, rnd = 32'h0001_3F12;
	logic [7:0] req_set = 8'h00, dreq_i, dack_n_o, flush_cnt = 8'h00;
	logic casc = 1'b0, slow = 1'b0, prev_all = 1'b1, pci_abort_i = 1'b0;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
	logic [31:0] s_axi_rdata_o;
	logic dack_oe_n_o, aen_o, aen_oe_n_o, bale_o, tc_o, tc_oe_n_o, isa_addr_oe_n_o;
	logic [23:0] isa_addr_o, seen_a;
	logic memr_n_o, memw_n_o, smemr_n_o, smemw_n_o, ior_n_o, iow_n_o, refresh_n_i, refresh_n_o;
	logic refresh_oe_n_o, chrdy_i, pci_hold_request_n_o, isa_stall_o, buf_flush_o, io0_forward_o;
	logic [15:0] a;
	logic [37:0] xq[$];
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	int bad_count = 0, total_checks = 0, cyc = 0;
	idrc_top u_idrc_top (.clk_sys_i, .rst_n_i, .ce_i(1'b1), .s_axi_awaddr_i, .s_axi_awvalid_i,
		.s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i, .s_axi_wready_o,
		.s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
		.s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
		.dreq_i, .dack_n_o, .dack_oe_n_o, .aen_o, .aen_oe_n_o, .bale_o, .tc_i, .tc_o, .tc_oe_n_o,
		.isa_addr_o, .isa_addr_oe_n_o, .memr_n_o, .memw_n_o, .smemr_n_o, .smemw_n_o, .ior_n_o,
		.iow_n_o, .refresh_n_i, .refresh_n_o, .refresh_oe_n_o, .chrdy_i, .refresh_tick_i,
		.pci_abort_i, .pci_hold_acknowledge_n_i, .pci_hold_request_n_o, .isa_stall_o,
		.buf_flush_o, .io0_forward_o);
	idrc_isa_model u_idrc_isa_model (.clk_sys_i, .req_set_i(req_set), .casc_i(casc),
		.slow_i(slow), .dack_n_i(dack_n_o), .tc_i(tc_o), .memr_n_i(memr_n_o), .dreq_o(dreq_i),
		.chrdy_o(chrdy_i), .refresh_n_o(refresh_n_i));
	initial forever #50 clk_sys_i = ~clk_sys_i;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic stop_test();
		if (bad_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [37:0] exp, input logic [37:0] got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic note(input logic [7:0] d, input logic [23:0] ad, input logic [5:0] s);
		xq.push_back({d, ad, s});
	endtask
	task automatic wr(input logic [11:0] ad, input logic [31:0] d, input logic [1:0] resp);
		bq.push_back(resp);
		@(posedge clk_sys_i);
		s_axi_awaddr_i <= ad;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			if (s_axi_awready_o)
				s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o)
				s_axi_wvalid_i <= 1'b0;
		end while (!s_axi_bvalid_o);
		s_axi_bready_i <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] ad, input logic [33:0] exp);
		rq.push_back(exp);
		@(posedge clk_sys_i);
		s_axi_araddr_i <= ad;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			if (s_axi_arready_o)
				s_axi_arvalid_i <= 1'b0;
		end while (!s_axi_rvalid_o);
		s_axi_rready_i <= 1'b0;
	endtask
	task automatic prog(input logic [2:0] c, input logic [15:0] ad, input logic [15:0] n,
		input logic [7:0] pg, input logic [7:0] md);
		wr({4'h1, 1'b0, c, 4'h0}, {16'h0000, ad}, `IDRC_RESP_OKAY);
		wr({4'h1, 1'b0, c, 4'h4}, {16'h0000, n}, `IDRC_RESP_OKAY);
		wr({4'h1, 1'b0, c, 4'h8}, {24'h00_0000, pg}, `IDRC_RESP_OKAY);
		wr({4'h1, 1'b0, c, 4'hC}, {24'h00_0000, md}, `IDRC_RESP_OKAY);
	endtask
	task automatic pulse_req(input logic [7:0] m);
		req_set <= m;
		@(posedge clk_sys_i);
		req_set <= 8'h00;
		while (xq.size() != 0)
			@(posedge clk_sys_i);
		repeat (20) @(posedge clk_sys_i);
	endtask
	always @(posedge clk_sys_i) pci_hold_acknowledge_n_i <= pci_hold_request_n_o;
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			stop_test();
		end
	end
	// watcher: first strobe edge of a transfer or refresh, and bus answers
	always @(posedge clk_sys_i) begin
		seen_a = (!refresh_n_o || !refresh_n_i) ? {16'h0000, isa_addr_o[7:0]} : isa_addr_o;
		prev_all <= memr_n_o & memw_n_o & ior_n_o & iow_n_o;
		if (buf_flush_o === 1'b1)
			flush_cnt <= flush_cnt + 8'h01;
		if (rst_n_i && prev_all && !(memr_n_o & memw_n_o & ior_n_o & iow_n_o))
			check("transfer", xq.size() ? xq.pop_front() : 38'h0, {dack_n_o, seen_a, memr_n_o,
				memw_n_o, smemr_n_o, smemw_n_o, ior_n_o, iow_n_o});
		if (rst_n_i && prev_all && !(memr_n_o & memw_n_o & ior_n_o & iow_n_o))
			check("addr drive", 38'h0, {37'h0, isa_addr_oe_n_o});
		if (s_axi_rvalid_o && s_axi_rready_i)
			check("read", rq.size() ? rq.pop_front() : 34'h0, {s_axi_rresp_o, s_axi_rdata_o});
		if (s_axi_bvalid_o && s_axi_bready_i)
			check("bresp", bq.size() ? bq.pop_front() : 2'h3, s_axi_bresp_o);
	end
	initial begin
		repeat (3) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		rd(12'h14C, {`IDRC_RESP_OKAY, 32'h0000_0030});
		rd(12'h0F0, {`IDRC_RESP_SLVERR, 32'h0000_0000});
		wr(12'h0F0, 32'h0000_0001, `IDRC_RESP_SLVERR);
		wr(`IDRC_MASK_OFS, 32'h0000_0000, `IDRC_RESP_OKAY);
		// byte channel, autoinit, started by software
		rnd = lfsr(rnd);
		a = rnd[15:0];
		prog(3'h1, a, 16'h0001, 8'h00, 8'h15);
		note(8'hFD, {8'h00, a}, 6'b101001);
		note(8'hFD, {8'h00, a + 16'h0001}, 6'b101001);
		wr(`IDRC_REQ_OFS, 32'h0000_0002, `IDRC_RESP_OKAY);
		pulse_req(8'h00);
		rd(12'h110, {`IDRC_RESP_OKAY, 16'h0000, a});
		// word channel from a hardware request
		rnd = lfsr(rnd);
		a = {2'b00, rnd[13:0]};
		prog(3'h5, a, 16'h0002, 8'h00, 8'h12);
		for (int k = 0; k < 3; k++)
			note(8'hDF, {7'h00, a + 16'(k), 1'b0}, 6'b010110);
		pulse_req(8'h20);
		// high page set: memory strobes held off, mask set at terminal count
		wr(`IDRC_HIPAGE_OFS, 32'h0000_0001, `IDRC_RESP_OKAY);
		rnd = lfsr(rnd);
		a = rnd[15:0];
		prog(3'h1, a, 16'h0000, 8'h40, 8'h11);
		note(8'hFD, {8'h40, a}, 6'b111101);
		wr(`IDRC_REQ_OFS, 32'h0000_0002, `IDRC_RESP_OKAY);
		pulse_req(8'h00);
		rd(`IDRC_MASK_OFS, {`IDRC_RESP_OKAY, 32'h0000_0022});
		wr(`IDRC_HIPAGE_OFS, 32'h0000_0000, `IDRC_RESP_OKAY);
		wr(`IDRC_MASK_OFS, 32'h0000_0000, `IDRC_RESP_OKAY);
		// three queued refreshes, stretched by a slow memory
		slow <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			note(8'hFF, {16'h0000, 8'(k)}, 6'b010111);
			@(posedge clk_sys_i);
			refresh_tick_i <= 1'b1;
			@(posedge clk_sys_i);
			refresh_tick_i <= 1'b0;
		end
		pulse_req(8'h00);
		slow <= 1'b0;
		// cascaded master asks for a refresh while it owns the bus
		prog(3'h5, 16'h0000, 16'h0000, 8'h00, 8'h30);
		casc <= 1'b1;
		note(8'hDF, {16'h0000, 8'h03}, 6'b011111);
		pulse_req(8'h20);
		casc <= 1'b0;
		// fast timing on channel 2, increment single reads only
		wr(`IDRC_FAST_OFS, 32'h0000_000A, `IDRC_RESP_OKAY);
		rnd = lfsr(rnd);
		a = {1'b0, rnd[14:0]};
		prog(3'h2, a, 16'h0003, 8'h00, 8'h12);
		for (int k = 0; k < 4; k++)
			note(8'hFB, {8'h00, a + 16'(k)}, 6'b010110);
		pci_abort_i <= 1'b1;
		pulse_req(8'h04);
		pci_abort_i <= 1'b0;
		check("flush", 38'h1, {30'h0, flush_cnt});
		rd(`IDRC_STAT_OFS, {`IDRC_RESP_OKAY, 32'h0010_0026});
		// second reset with the strap set: external dma mode
		rst_n_i <= 1'b0;
		tc_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		repeat (8) @(posedge clk_sys_i);
		check("strap", 38'h7, {35'h0, io0_forward_o, aen_oe_n_o, dack_oe_n_o});
		stop_test();
	end
endmodule
`default_nettype wire
